// ===== rtl/amd_pkg.sv
// Shared constants and carrier types for the auto mute and dither configuration block
package amd_pkg;

    // Register offsets
    localparam logic [7:0] OFS_AUTO_MUTE_CONTROL   = 8'h41;
    localparam logic [7:0] OFS_ANALOG_MUTE_DELAY   = 8'h42;
    localparam logic [7:0] OFS_PRIMARY_DITHER_GAIN = 8'h43;
    localparam logic [7:0] OFS_LEFT_DC_HIGH        = 8'h44;
    localparam logic [7:0] OFS_LEFT_DC_LOW         = 8'h45;

    // Values after reset
    localparam logic [7:0] RST_AUTO_MUTE_CONTROL   = 8'h07;
    localparam logic [7:0] RST_ANALOG_MUTE_DELAY   = 8'h19;
    localparam logic [7:0] RST_PRIMARY_DITHER_GAIN = 8'h00;
    localparam logic [7:0] RST_LEFT_DC_HIGH        = 8'h00;
    localparam logic [7:0] RST_LEFT_DC_LOW         = 8'h00;
    localparam logic [7:0] RDATA_UNMAPPED          = 8'h00;

    // Field positions in the auto mute control register
    localparam int POS_MUTE_COUPLING = 2;
    localparam int POS_MUTE_EN_BIT1  = 1;
    localparam int POS_MUTE_EN_BIT0  = 0;

    // Field positions in the primary dither gain register
    localparam int POS_LEFT_AC_GAIN   = 6;
    localparam int POS_RIGHT_AC_GAIN  = 4;
    localparam int POS_LEFT_DEM_GAIN  = 2;
    localparam int POS_RIGHT_DEM_GAIN = 0;

    // DC dither amount is Q0.11; 1.0 is 1/32 of full scale (2^-5 * 2^-11 = 2^-16)
    localparam int DC_AMOUNT_W   = 11;
    localparam int DC_HIGH_W     = 3;
    localparam int DC_FS_LOG2    = 16;

    // Gain codes
    localparam logic [1:0] CODE_AC_0125  = 2'h0;
    localparam logic [1:0] CODE_AC_025   = 2'h1;
    localparam logic [1:0] CODE_AC_05    = 2'h2;
    localparam logic [1:0] CODE_DEM_05   = 2'h0;
    localparam logic [1:0] CODE_DEM_10   = 2'h1;

    // AC gain as unsigned Q0.3, DEM gain as unsigned Q1.1
    localparam logic [2:0] AC_GAIN_0125  = 3'h1;
    localparam logic [2:0] AC_GAIN_025   = 3'h2;
    localparam logic [2:0] AC_GAIN_05    = 3'h4;
    localparam logic [2:0] AC_GAIN_NONE  = 3'h0;
    localparam logic [1:0] DEM_GAIN_05   = 2'h1;
    localparam logic [1:0] DEM_GAIN_10   = 2'h2;

    typedef struct packed {
        logic [2:0] left_ac;
        logic [2:0] right_ac;
        logic [1:0] left_dem;
        logic [1:0] right_dem;
    } amd_dither_gain_t;

    typedef struct packed {
        logic       coupling;
        logic       enable_bit1;
        logic       enable_bit0;
    } amd_mute_cfg_t;

endpackage

// ===== rtl/amd_analog_delay.sv
// Delay from completed digital mute to analog mute, counted in frame periods
`timescale 1ns/1ps
module amd_analog_delay (
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic       frame_tick,
    input  wire logic       mute_done,
    input  wire logic [7:0] delay_count,
    output logic            analog_mute
);

    logic [7:0] frames_q;
    logic       analog_mute_q;

    // Frame counter restarts whenever the digital mute is released
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            frames_q <= 8'h00;
        end else if (!mute_done) begin
            frames_q <= 8'h00;
        end else if (!analog_mute_q && frames_q != delay_count && frame_tick) begin
            frames_q <= frames_q + 8'h01; // [R7]
        end
    end

    // Zero delay asserts on the cycle after the mute is seen complete
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            analog_mute_q <= 1'b0;
        end else if (!mute_done) begin
            analog_mute_q <= 1'b0;
        end else if (frames_q == delay_count) begin
            analog_mute_q <= 1'b1; // [R6]
        end
    end

    assign analog_mute = analog_mute_q;

endmodule // amd_analog_delay

// ===== rtl/amd_config.sv
// Auto mute, analog mute delay and primary dither configuration register bank
`timescale 1ns/1ps
// Operation
// [R1] Auto mute starts when upstream zero detection reports the configured run length.
// [R2] Coupling bit 0 mutes channels independently; 1 mutes both only when both qualify.
// [R3] Bit 1 enables auto mute of the right channel.
// [R4] Bit 0 enables auto mute of the left channel.
// [R5] Coupled and one channel disabled means neither channel ever auto mutes.
// [R6] Analog mute follows completed digital mute after the programmed delay.
// [R7] Delay value N gives N frame periods; zero gives no delay, maximum 255.
// [R8] AC dither gain code 00 is 0.125, code 01 is 0.25.
// [R9] DEM dither gain code 00 is 0.5, code 01 is 1.0.
// [R10] Host writes only codes 00 or 01 to DEM gain fields.
// [R11] DC dither, Q0.11 with 1.0 at 1/32 full scale, adds to left input.
// [R12] Left DC amount joins three low bits at 0x44 with byte at 0x45.
// [R13] Host writes only codes 00 or 01 to AC gain fields.
module amd_config #(
    parameter int SAMPLE_W = 24
) (
    input  wire logic                       clk_sys,
    input  wire logic                       reset_n,
    // Register port
    input  wire logic [7:0]                 reg_addr,
    input  wire logic [7:0]                 reg_wdata,
    input  wire logic                       reg_wr,
    output logic [7:0]                      reg_rdata,
    // Frame clock pin
    input  wire logic                       lrclk_pin,
    // Zero detection from the sample path
    input  wire logic                       zero_left,
    input  wire logic                       zero_right,
    output logic                            auto_mute_left,
    output logic                            auto_mute_right,
    // Digital mute status and analog mute
    input  wire logic                       digital_mute_done,
    output logic                            analog_mute,
    // Dither settings
    output amd_pkg::amd_dither_gain_t       dither_gain,
    output logic [amd_pkg::DC_AMOUNT_W-1:0] left_primary_dc_amount,
    // Left primary modulator input path
    input  wire logic signed [SAMPLE_W-1:0] mod_left_in,
    input  wire logic                       mod_left_valid,
    output logic signed [SAMPLE_W-1:0]      mod_left_out,
    output logic                            mod_left_out_valid
);

    localparam int DC_SHIFT = SAMPLE_W - 1 - amd_pkg::DC_FS_LOG2;

    // Narrower samples would push the dither shift below zero
    if (SAMPLE_W < amd_pkg::DC_FS_LOG2 + 1) begin : g_width_check
        $error("SAMPLE_W too narrow for DC dither scaling");
    end

    logic [7:0]            auto_mute_control_q;
    logic [7:0]            analog_mute_delay_q;
    logic [7:0]            primary_dither_gain_q;
    logic [7:0]            left_dc_high_q;
    logic [7:0]            left_dc_low_q;
    logic [7:0]            rdata_d;
    logic [7:0]            rdata_q;
    logic [2:0]            lrclk_sync_q;
    logic                  frame_tick;
    amd_pkg::amd_mute_cfg_t mute_cfg;
    logic                  qual_left;
    logic                  qual_right;
    logic                  mute_left_d;
    logic                  mute_right_d;
    logic                  mute_left_q;
    logic                  mute_right_q;
    amd_pkg::amd_dither_gain_t gain_d;
    amd_pkg::amd_dither_gain_t gain_q;
    logic [amd_pkg::DC_AMOUNT_W-1:0] dc_amount_q;
    logic signed [SAMPLE_W:0] dc_ext;
    logic signed [SAMPLE_W:0] sum;
    logic signed [SAMPLE_W-1:0] mod_out_q;
    logic                  mod_valid_q;

    // Register writes; reserved bits are stored and read back
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            auto_mute_control_q   <= amd_pkg::RST_AUTO_MUTE_CONTROL;
            analog_mute_delay_q   <= amd_pkg::RST_ANALOG_MUTE_DELAY;
            primary_dither_gain_q <= amd_pkg::RST_PRIMARY_DITHER_GAIN;
            left_dc_high_q        <= amd_pkg::RST_LEFT_DC_HIGH;
            left_dc_low_q         <= amd_pkg::RST_LEFT_DC_LOW;
        end else if (reg_wr) begin
            case (reg_addr)
                amd_pkg::OFS_AUTO_MUTE_CONTROL:   auto_mute_control_q   <= reg_wdata;
                amd_pkg::OFS_ANALOG_MUTE_DELAY:   analog_mute_delay_q   <= reg_wdata;
                amd_pkg::OFS_PRIMARY_DITHER_GAIN: primary_dither_gain_q <= reg_wdata;
                amd_pkg::OFS_LEFT_DC_HIGH:        left_dc_high_q        <= reg_wdata;
                amd_pkg::OFS_LEFT_DC_LOW:         left_dc_low_q         <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Read data, one cycle after the address is presented
    always_comb begin
        case (reg_addr)
            amd_pkg::OFS_AUTO_MUTE_CONTROL:   rdata_d = auto_mute_control_q;
            amd_pkg::OFS_ANALOG_MUTE_DELAY:   rdata_d = analog_mute_delay_q;
            amd_pkg::OFS_PRIMARY_DITHER_GAIN: rdata_d = primary_dither_gain_q;
            amd_pkg::OFS_LEFT_DC_HIGH:        rdata_d = left_dc_high_q;
            amd_pkg::OFS_LEFT_DC_LOW:         rdata_d = left_dc_low_q;
            default:                          rdata_d = amd_pkg::RDATA_UNMAPPED;
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= amd_pkg::RDATA_UNMAPPED;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // Frame clock pin: two flops, then a third for the rising edge
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            lrclk_sync_q <= 3'h0;
        end else begin
            lrclk_sync_q <= {lrclk_sync_q[1:0], lrclk_pin};
        end
    end

    assign frame_tick = lrclk_sync_q[1] & ~lrclk_sync_q[2];

    // Auto mute decision
    assign mute_cfg.coupling    = auto_mute_control_q[amd_pkg::POS_MUTE_COUPLING];
    assign mute_cfg.enable_bit1 = auto_mute_control_q[amd_pkg::POS_MUTE_EN_BIT1];
    assign mute_cfg.enable_bit0 = auto_mute_control_q[amd_pkg::POS_MUTE_EN_BIT0];

    // Zero inputs already carry the run length check upstream
    assign qual_left  = zero_left & mute_cfg.enable_bit0;  // [R1] [R4]
    assign qual_right = zero_right & mute_cfg.enable_bit1; // [R1] [R3]

    always_comb begin
        if (mute_cfg.coupling) begin
            // A disabled channel never qualifies, so neither side mutes
            mute_left_d  = qual_left & qual_right; // [R2] [R5]
            mute_right_d = qual_left & qual_right; // [R2] [R5]
        end else begin
            mute_left_d  = qual_left;  // [R2]
            mute_right_d = qual_right; // [R2]
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mute_left_q  <= 1'b0;
            mute_right_q <= 1'b0;
        end else begin
            mute_left_q  <= mute_left_d;
            mute_right_q <= mute_right_d;
        end
    end

    assign auto_mute_left  = mute_left_q;
    assign auto_mute_right = mute_right_q;

    amd_analog_delay u_analog_delay (
        .clk_sys     (clk_sys),
        .reset_n     (reset_n),
        .frame_tick  (frame_tick),
        .mute_done   (digital_mute_done),
        .delay_count (analog_mute_delay_q),
        .analog_mute (analog_mute)
    );

    // Gain decode; unlisted AC codes follow the secondary modulator meaning
    function automatic logic [2:0] ac_gain(input logic [1:0] code);
        case (code)
            amd_pkg::CODE_AC_0125: ac_gain = amd_pkg::AC_GAIN_0125; // [R8]
            amd_pkg::CODE_AC_025:  ac_gain = amd_pkg::AC_GAIN_025;  // [R8]
            amd_pkg::CODE_AC_05:   ac_gain = amd_pkg::AC_GAIN_05;
            default:               ac_gain = amd_pkg::AC_GAIN_NONE;
        endcase
    endfunction

    // Reserved DEM codes are the host's fault; hold them at unity
    function automatic logic [1:0] dem_gain(input logic [1:0] code);
        case (code)
            amd_pkg::CODE_DEM_05: dem_gain = amd_pkg::DEM_GAIN_05; // [R9]
            amd_pkg::CODE_DEM_10: dem_gain = amd_pkg::DEM_GAIN_10; // [R9]
            default:              dem_gain = amd_pkg::DEM_GAIN_10; // [R10]
        endcase
    endfunction

    always_comb begin
        gain_d.left_ac   = ac_gain(primary_dither_gain_q[amd_pkg::POS_LEFT_AC_GAIN +: 2]);
        gain_d.right_ac  = ac_gain(primary_dither_gain_q[amd_pkg::POS_RIGHT_AC_GAIN +: 2]);
        gain_d.left_dem  = dem_gain(primary_dither_gain_q[amd_pkg::POS_LEFT_DEM_GAIN +: 2]);
        gain_d.right_dem = dem_gain(primary_dither_gain_q[amd_pkg::POS_RIGHT_DEM_GAIN +: 2]);
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            gain_q      <= '0;
            dc_amount_q <= '0;
        end else begin
            gain_q      <= gain_d;
            dc_amount_q <= {left_dc_high_q[amd_pkg::DC_HIGH_W-1:0], left_dc_low_q}; // [R12]
        end
    end

    assign dither_gain            = gain_q;
    assign left_primary_dc_amount = dc_amount_q;

    // DC dither lands in the low part of the sample; saturate on overflow
    assign dc_ext = (SAMPLE_W+1)'(dc_amount_q) <<< DC_SHIFT; // [R11]
    assign sum    = (SAMPLE_W+1)'(mod_left_in) + dc_ext;      // [R11]

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mod_out_q   <= '0;
            mod_valid_q <= 1'b0;
        end else begin
            mod_valid_q <= mod_left_valid;
            if (mod_left_valid) begin
                if (sum[SAMPLE_W] != sum[SAMPLE_W-1]) begin
                    mod_out_q <= {1'b0, {(SAMPLE_W-1){1'b1}}};
                end else begin
                    mod_out_q <= sum[SAMPLE_W-1:0]; // [R11]
                end
            end
        end
    end

    assign mod_left_out       = mod_out_q;
    assign mod_left_out_valid = mod_valid_q;

endmodule // amd_config

// ===== verif/amd_config_monitor.sv
// Assertion checker for the auto mute and dither configuration bank
`timescale 1ns/1ps
module amd_config_monitor (
    input wire logic                      clk_sys,
    input wire logic                      reset_n,
    input wire logic [7:0]                reg_addr,
    input wire logic [7:0]                reg_wdata,
    input wire logic                      reg_wr,
    input wire logic [7:0]                reg_rdata,
    input wire logic                      zero_left,
    input wire logic                      zero_right,
    input wire logic                      auto_mute_left,
    input wire logic                      auto_mute_right,
    input wire logic                      digital_mute_done,
    input wire logic                      analog_mute,
    input wire amd_pkg::amd_dither_gain_t dither_gain,
    input wire logic [10:0]               left_primary_dc_amount,
    input wire logic                      mod_left_valid,
    input wire logic                      mod_left_out_valid
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    logic [7:0] mute_q;
    logic [7:0] dly_q;
    logic       ml;
    logic       mr;
    logic       mapped;
    // Shadow copies so expectations do not lean on the design's own state
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mute_q <= amd_pkg::RST_AUTO_MUTE_CONTROL;
            dly_q <= amd_pkg::RST_ANALOG_MUTE_DELAY;
        end else if (reg_wr && reg_addr == amd_pkg::OFS_AUTO_MUTE_CONTROL) begin
            mute_q <= reg_wdata;
        end else if (reg_wr && reg_addr == amd_pkg::OFS_ANALOG_MUTE_DELAY) begin
            dly_q <= reg_wdata;
        end
    end
    assign mapped = reg_addr inside {[8'h41:8'h45]};
    assign ml = zero_left & mute_q[0] & (~mute_q[2] | (zero_right & mute_q[1]));
    assign mr = zero_right & mute_q[1] & (~mute_q[2] | (zero_left & mute_q[0]));
    sequence s_wr43; reg_wr && reg_addr == amd_pkg::OFS_PRIMARY_DITHER_GAIN; endsequence
    sequence s_wr45; reg_wr && reg_addr == amd_pkg::OFS_LEFT_DC_LOW; endsequence
    sequence s_quiet; !digital_mute_done ##1 !digital_mute_done; endsequence
    property p_unmapped; !mapped |=> reg_rdata == amd_pkg::RDATA_UNMAPPED; endproperty
    property p_wr_rd;
        reg_wr && mapped ##1 reg_addr == $past(reg_addr) |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    property p_mute_l; ##1 auto_mute_left == $past(ml); endproperty
    property p_mute_r; ##1 auto_mute_right == $past(mr); endproperty
    property p_ac;
        s_wr43 ##0 reg_wdata[7:6] == amd_pkg::CODE_AC_025 |->
            ##2 dither_gain.left_ac == amd_pkg::AC_GAIN_025;
    endproperty
    property p_dem;
        s_wr43 ##0 reg_wdata[1:0] == amd_pkg::CODE_DEM_05 |->
            ##2 dither_gain.right_dem == amd_pkg::DEM_GAIN_05;
    endproperty
    property p_dc; s_wr45 |-> ##2 left_primary_dc_amount[7:0] == $past(reg_wdata, 2); endproperty
    property p_amute0; dly_q == 8'h00 && $rose(digital_mute_done) |-> ##[1:2] analog_mute; endproperty
    property p_analog_mute_off; s_quiet |-> !analog_mute; endproperty
    property p_valid; ##1 mod_left_out_valid == $past(mod_left_valid); endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_wr_rd: assert property (p_wr_rd) else $error("readback differs");
    a_mute_l: assert property (p_mute_l) else $error("left auto mute wrong");
    a_mute_r: assert property (p_mute_r) else $error("right auto mute wrong");
    a_ac: assert property (p_ac) else $error("ac gain wrong");
    a_dem: assert property (p_dem) else $error("dem gain wrong");
    a_dc: assert property (p_dc) else $error("dc amount wrong");
    a_amute0: assert property (p_amute0) else $error("zero delay mute late");
    a_analog_mute_off: assert property (p_analog_mute_off) else $error("analog mute without done");
    a_valid: assert property (p_valid) else $error("output valid wrong");
endmodule // amd_config_monitor
bind amd_config amd_config_monitor u_amd_config_monitor (
    .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rdata(reg_rdata), .zero_left(zero_left), .zero_right(zero_right),
    .auto_mute_left(auto_mute_left), .auto_mute_right(auto_mute_right),
    .digital_mute_done(digital_mute_done), .analog_mute(analog_mute),
    .dither_gain(dither_gain), .left_primary_dc_amount(left_primary_dc_amount),
    .mod_left_valid(mod_left_valid), .mod_left_out_valid(mod_left_out_valid));

// ===== verif/amd_config_tb.sv
// Self-checking bench for the auto mute and dither configuration bank
`timescale 1ns/1ps
module amd_config_tb;
    localparam int SW = 24;
    logic                      clk_sys = 1'b0;
    logic                      reset_n = 1'b0;
    logic [7:0]                reg_addr = 8'h00;
    logic [7:0]                reg_wdata = 8'h00;
    logic                      reg_wr = 1'b0;
    logic                      lrclk_pin = 1'b0;
    logic                      zero_left = 1'b0;
    logic                      zero_right = 1'b0;
    logic                      digital_mute_done = 1'b0;
    logic [SW-1:0]             mod_left_in = 24'h000000;
    logic                      mod_left_valid = 1'b0;
    logic [7:0]                reg_rdata;
    logic                      auto_mute_left;
    logic                      auto_mute_right;
    logic                      analog_mute;
    amd_pkg::amd_dither_gain_t dither_gain;
    logic [10:0]               dc_amount;
    logic [SW-1:0]             mod_left_out;
    logic                      mod_left_out_valid;
    int                        n_mismatch = 0;
    int                        check_count = 0;
    int                        seed = 6;
    int                        cycles = 0;
    logic [7:0]                dv;
    logic [7:0]                hi;
    logic [7:0]                lo;
    logic [SW-1:0]             x;
    logic [7:0] ofs [7] = '{8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h40, 8'h46};
    logic [7:0] rst [7] = '{8'h07, 8'h19, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] dly [4] = '{8'h00, 8'h01, 8'h03, 8'hFF};

    always #12.5 clk_sys = ~clk_sys;

    amd_config #(.SAMPLE_W(SW)) u_amd_config (
        .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rdata(reg_rdata), .lrclk_pin(lrclk_pin),
        .zero_left(zero_left), .zero_right(zero_right), .auto_mute_left(auto_mute_left),
        .auto_mute_right(auto_mute_right), .digital_mute_done(digital_mute_done),
        .analog_mute(analog_mute), .dither_gain(dither_gain),
        .left_primary_dc_amount(dc_amount), .mod_left_in(mod_left_in),
        .mod_left_valid(mod_left_valid), .mod_left_out(mod_left_out),
        .mod_left_out_valid(mod_left_out_valid));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    // Strobe dropped for one cycle so writes never merge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        @(posedge clk_sys);
        #1 chk(reg_rdata, e);
    endtask
    task automatic settle();
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    function automatic logic [1:0] exp_mute(input logic [2:0] c, input logic [1:0] z);
        logic ql;
        logic qr;
        ql = z[0] & c[0];
        qr = z[1] & c[1];
        return c[2] ? {2{ql & qr}} : {qr, ql};
    endfunction
    function automatic logic [9:0] exp_gain(input logic [3:0] c);
        return {c[3] ? amd_pkg::AC_GAIN_025 : amd_pkg::AC_GAIN_0125,
                c[2] ? amd_pkg::AC_GAIN_025 : amd_pkg::AC_GAIN_0125,
                c[1] ? amd_pkg::DEM_GAIN_10 : amd_pkg::DEM_GAIN_05,
                c[0] ? amd_pkg::DEM_GAIN_10 : amd_pkg::DEM_GAIN_05};
    endfunction
    function automatic logic [SW-1:0] exp_mod(input logic [SW-1:0] v, input logic [10:0] dc);
        logic signed [SW+1:0] s;
        s = $signed({{2{v[SW-1]}}, v}) + $signed({{(SW-16){1'b0}}, dc, 7'h00});
        return (s > $signed({3'b000, {(SW-1){1'b1}}})) ? {1'b0, {(SW-1){1'b1}}} : s[SW-1:0];
    endfunction
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            end_sim();
        end
    end

    initial begin
        repeat (8) @(posedge clk_sys);
        reset_n <= 1'b1;
        for (int i = 0; i < 7; i++) rd(ofs[i], rst[i]);
        for (int i = 0; i < 7; i++) begin
            dv = $random(seed);
            if (i == 2) dv = dv & 8'h55;
            wr(ofs[i], dv);
            rd(ofs[i], (i > 4) ? 8'h00 : dv);
        end
        for (int c = 0; c < 8; c++) begin
            wr(amd_pkg::OFS_AUTO_MUTE_CONTROL, {5'h00, c[2:0]});
            for (int z = 0; z < 4; z++) begin
                @(posedge clk_sys);
                zero_left <= z[0];
                zero_right <= z[1];
                settle();
                chk({auto_mute_right, auto_mute_left}, exp_mute(c[2:0], z[1:0]));
            end
        end
        zero_left <= 1'b0;
        zero_right <= 1'b0;
        for (int c = 0; c < 16; c++) begin
            wr(amd_pkg::OFS_PRIMARY_DITHER_GAIN, {1'b0, c[3], 1'b0, c[2], 1'b0, c[1], 1'b0, c[0]});
            settle();
            chk(dither_gain, exp_gain(c[3:0]));
        end
        for (int i = 0; i < 8; i++) begin
            hi = $random(seed);
            lo = $random(seed);
            wr(amd_pkg::OFS_LEFT_DC_HIGH, hi);
            wr(amd_pkg::OFS_LEFT_DC_LOW, lo);
            settle();
            chk(dc_amount, {hi[2:0], lo});
            x = (i == 0) ? 24'h7FFFF0 : $random(seed);
            @(posedge clk_sys);
            mod_left_in <= x;
            mod_left_valid <= 1'b1;
            @(posedge clk_sys);
            mod_left_valid <= 1'b0;
            #1 chk(mod_left_out_valid, 1'b1);
            chk(mod_left_out, exp_mod(x, {hi[2:0], lo}));
        end
        // Frame edges only while done is high, so each delay is counted exactly
        for (int n = 0; n < 4; n++) begin
            wr(amd_pkg::OFS_ANALOG_MUTE_DELAY, dly[n]);
            @(posedge clk_sys);
            digital_mute_done <= 1'b1;
            repeat (4) @(posedge clk_sys);
            for (int k = 0; k < dly[n]; k++) begin
                #1 chk(analog_mute, 1'b0);
                @(posedge clk_sys);
                lrclk_pin <= 1'b1;
                repeat (4) @(posedge clk_sys);
                lrclk_pin <= 1'b0;
                repeat (4) @(posedge clk_sys);
            end
            #1 chk(analog_mute, 1'b1);
            @(posedge clk_sys);
            digital_mute_done <= 1'b0;
            settle();
            chk(analog_mute, 1'b0);
        end
        end_sim();
    end
endmodule // amd_config_tb
